// ---- ics_cfg.svh ----
// Constants for the channel-select serial target
`ifndef ICS_CFG_SVH
`define ICS_CFG_SVH

// ----------------------------------------
// Field layout
// ----------------------------------------
`define ICS_CHAN_BITS      3
`define ICS_ADDR_BITS      7
`define ICS_RW_POS         0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ICS_CTRL_RESET     3'h0
`define ICS_RW_READ        1'h1
`define ICS_BYTE_DONE      4'h8
`define ICS_CNT_ZERO       4'h0
`define ICS_CNT_STEP       4'h1

`endif

// ---- ics_master.sv ----
// Upstream bus controller model for the channel-select target
`timescale 1ns/10ps

module ics_master
#(
   parameter int QUARTER = 60
)
(
   // Pacing
   input  wire logic       slow,
   // Bus lines
   output logic            scl,
   output logic            sda_drv,
   input  wire logic       sda,
   // Received units
   output logic      [7:0] rx_data,
   output logic            rx_stb
);
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b0;
      rx_data = 8'h00;
      rx_stb = 1'b0;
   end

   task automatic wt(input int n);
      #(n * (slow ? 3 : 1) * QUARTER);
   endtask

   task automatic bit_io(input logic b, output logic r);
      wt(1);
      sda_drv <= !b;
      wt(1);
      scl <= 1'b1;
      wt(2);
      r = sda;
      scl <= 1'b0;
   endtask

   task automatic start();
      wt(1);
      sda_drv <= 1'b0;
      wt(1);
      scl <= 1'b1;
      wt(2);
      sda_drv <= 1'b1;
      wt(2);
      scl <= 1'b0;
   endtask

   task automatic stop();
      wt(1);
      sda_drv <= 1'b1;
      wt(1);
      scl <= 1'b1;
      wt(2);
      sda_drv <= 1'b0;
      wt(2);
   endtask

   task automatic wbyte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      rx_data = {7'h00, r};
      rx_stb = !rx_stb;
   endtask

   task automatic rbyte(input logic more);
      logic [7:0] d;
      logic       r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!more, r);
      rx_data = d;
      rx_stb = !rx_stb;
   endtask
endmodule

// ---- ics_pkg.sv ----
// Types for the channel-select serial target
package ics_pkg;

   // ----------------------------------------
   // Protocol states
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      ICS_IDLE    = 3'b000,
      ICS_ADDR    = 3'b001,
      ICS_ADDR_AK = 3'b010,
      ICS_WR_DATA = 3'b011,
      ICS_WR_AK   = 3'b100,
      ICS_RD_DATA = 3'b101,
      ICS_RD_AK   = 3'b110
   } ics_state_e;

   // ----------------------------------------
   // Sampled bus lines
   // ----------------------------------------
   typedef struct packed
   {
      logic rst_n;
      logic scl;
      logic sda;
   } ics_line_s;

endpackage

// ---- ics_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps

module ics_sync
#(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] out_d;

   // ----------------------------------------
   // Per-bit agreement of stages two and three
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         assign out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : sync_out[i];
      end
   endgenerate

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         s1_q     <= RESET_VALUE;
         s2_q     <= RESET_VALUE;
         s3_q     <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end
      else
      begin
         s1_q     <= async_in;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         sync_out <= out_d;
      end
   end

endmodule

// ---- ics_target.sv ----
// Serial-bus target that loads and returns the channel-select byte
//
// Operation
// - Address with read/write low: write, acknowledged.
// - Low three written bits pick downstream channels.
// - Upper five written bits have no effect.
// - Any byte count; last byte before stop kept.
// - New selection applied only at stop.
// - Address with read/write high: read, acknowledged.
// - Read repeats byte per ack; nack ends.
// - No limit on bytes read.
// - Read low bits show the committed selection register, ahead of channel_enable.
// - Reset returns register and protocol to defaults.
`timescale 1ns/10ps
`include "ics_cfg.svh"
module ics_target
#(
   parameter int CHAN_BITS = `ICS_CHAN_BITS,
   parameter int ADDR_BITS = `ICS_ADDR_BITS
)
(
   // System clock and power-on reset
   input  wire logic                 clock,
   input  wire logic                 reset,
   // Link clock
   input  wire logic                 link_clock,
   // Reset pin
   input  wire logic                 reset_line_n,
   // Upstream bus
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe,
   // Device address strap
   input  wire logic [ADDR_BITS-1:0] device_address,
   // Switch control
   output logic      [CHAN_BITS-1:0] channel_enable
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   ics_pkg::ics_line_s   line;
   logic [ADDR_BITS-1:0] addr_s;
   logic                 scl_prev_q;
   logic                 sda_prev_q;
   ics_pkg::ics_state_e  state_q;
   ics_pkg::ics_state_e  state_d;
   logic [3:0]           cnt_q;
   logic [3:0]           cnt_d;
   logic [7:0]           shift_q;
   logic [7:0]           shift_d;
   logic [7:0]           tx_q;
   logic [7:0]           tx_d;
   logic                 ack_q;
   logic                 ack_d;
   logic                 oe_q;
   logic                 oe_d;
   logic [CHAN_BITS-1:0] pend_q;
   logic [CHAN_BITS-1:0] pend_d;
   logic                 pend_vld_q;
   logic                 pend_vld_d;
   logic [CHAN_BITS-1:0] ctrl_q;
   logic [CHAN_BITS-1:0] ctrl_d;
   logic                 tgl_q;
   logic                 tgl_d;
   logic                 tgl_s;
   logic                 tgl_prev_q;
   logic [CHAN_BITS-1:0] chan_q;
   // ----------------------------------------
   // Decoding
   // ----------------------------------------
   function automatic logic drive_low(input logic bit_value);
      drive_low = ~bit_value;
   endfunction
   wire       scl_rise   = line.scl & ~scl_prev_q;
   wire       scl_fall   = ~line.scl & scl_prev_q;
   wire       start_seen = line.scl & scl_prev_q & sda_prev_q & ~line.sda;
   wire       stop_seen  = line.scl & scl_prev_q & ~sda_prev_q & line.sda;
   wire       pin_reset  = ~line.rst_n;
   wire       addr_hit   = (shift_q[7:1] == addr_s);
   wire       byte_full  = (cnt_q == `ICS_BYTE_DONE);
   wire [7:0] read_byte  = {{(8-CHAN_BITS){1'h0}}, ctrl_q};
   wire [3:0] cnt_inc    = cnt_q + `ICS_CNT_STEP;
   // ----------------------------------------
   // Link-side input synchronisers
   // ----------------------------------------
   ics_sync #(.WIDTH(3), .RESET_VALUE(3'h7)) u_line_sync
   (
      .clock    (link_clock),
      .reset    (reset),
      .async_in ({reset_line_n, scl_in, sda_in}),
      .sync_out (line)
   );
   ics_sync #(.WIDTH(ADDR_BITS), .RESET_VALUE('0)) u_addr_sync
   (
      .clock    (link_clock),
      .reset    (reset),
      .async_in (device_address),
      .sync_out (addr_s)
   );
   // ----------------------------------------
   // Protocol next state
   // ----------------------------------------
   always_comb
   begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      shift_d    = shift_q;
      tx_d       = tx_q;
      ack_d      = ack_q;
      oe_d       = oe_q;
      pend_d     = pend_q;
      pend_vld_d = pend_vld_q;
      ctrl_d     = ctrl_q;
      tgl_d      = tgl_q;
      if (pin_reset)
      begin
         state_d    = ics_pkg::ICS_IDLE;
         cnt_d      = `ICS_CNT_ZERO;
         oe_d       = 1'h0;
         pend_vld_d = 1'h0;
         ctrl_d     = `ICS_CTRL_RESET;
         tgl_d      = tgl_q ^ (ctrl_q != `ICS_CTRL_RESET);
      end
      else if (stop_seen)
      begin
         state_d = ics_pkg::ICS_IDLE;
         oe_d    = 1'h0;
         if (pend_vld_q)
         begin
            ctrl_d     = pend_q;
            tgl_d      = ~tgl_q;
            pend_vld_d = 1'h0;
         end
      end
      else if (start_seen)
      begin
         state_d = ics_pkg::ICS_ADDR;
         cnt_d   = `ICS_CNT_ZERO;
         oe_d    = 1'h0;
      end
      else if (scl_rise && state_q != ics_pkg::ICS_IDLE)
      begin
         ack_d = ~line.sda;
         if (!byte_full)
         begin
            shift_d = {shift_q[6:0], line.sda};
            cnt_d   = cnt_inc;
         end
      end
      else if (scl_fall)
      begin
         unique case (state_q)
            ics_pkg::ICS_ADDR:
            begin
               if (byte_full)
               begin
                  state_d = addr_hit ? ics_pkg::ICS_ADDR_AK : ics_pkg::ICS_IDLE;
                  oe_d    = addr_hit;
               end
            end
            ics_pkg::ICS_ADDR_AK:
            begin
               cnt_d = `ICS_CNT_ZERO;
               if (shift_q[`ICS_RW_POS] == `ICS_RW_READ)
               begin
                  state_d = ics_pkg::ICS_RD_DATA;
                  oe_d    = drive_low(read_byte[7]);
                  tx_d    = {read_byte[6:0], 1'h0};
               end
               else
               begin
                  state_d = ics_pkg::ICS_WR_DATA;
                  oe_d    = 1'h0;
               end
            end
            ics_pkg::ICS_WR_DATA:
            begin
               if (byte_full)
               begin
                  pend_d     = shift_q[CHAN_BITS-1:0];
                  pend_vld_d = 1'h1;
                  state_d    = ics_pkg::ICS_WR_AK;
                  oe_d       = 1'h1;
               end
            end
            ics_pkg::ICS_WR_AK:
            begin
               state_d = ics_pkg::ICS_WR_DATA;
               cnt_d   = `ICS_CNT_ZERO;
               oe_d    = 1'h0;
            end
            ics_pkg::ICS_RD_DATA:
            begin
               if (byte_full)
               begin
                  state_d = ics_pkg::ICS_RD_AK;
                  oe_d    = 1'h0;
               end
               else
               begin
                  oe_d = drive_low(tx_q[7]);
                  tx_d = {tx_q[6:0], 1'h0};
               end
            end
            ics_pkg::ICS_RD_AK:
            begin
               if (ack_q)
               begin
                  state_d = ics_pkg::ICS_RD_DATA;
                  cnt_d   = `ICS_CNT_ZERO;
                  oe_d    = drive_low(read_byte[7]);
                  tx_d    = {read_byte[6:0], 1'h0};
               end
               else
               begin
                  state_d = ics_pkg::ICS_IDLE;
                  oe_d    = 1'h0;
               end
            end
            default:
            begin
               state_d = ics_pkg::ICS_IDLE;
               oe_d    = 1'h0;
            end
         endcase
      end
   end
   // ----------------------------------------
   // Link-domain registers
   // ----------------------------------------
   always_ff @(posedge link_clock or posedge reset)
   begin
      if (reset)
      begin
         scl_prev_q <= 1'h1;
         sda_prev_q <= 1'h1;
         state_q    <= ics_pkg::ICS_IDLE;
         cnt_q      <= `ICS_CNT_ZERO;
         shift_q    <= 8'h00;
         tx_q       <= 8'h00;
         ack_q      <= 1'h0;
         oe_q       <= 1'h0;
         pend_q     <= `ICS_CTRL_RESET;
         pend_vld_q <= 1'h0;
         ctrl_q     <= `ICS_CTRL_RESET;
         tgl_q      <= 1'h0;
      end
      else
      begin
         scl_prev_q <= line.scl;
         sda_prev_q <= line.sda;
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         shift_q    <= shift_d;
         tx_q       <= tx_d;
         ack_q      <= ack_d;
         oe_q       <= oe_d;
         pend_q     <= pend_d;
         pend_vld_q <= pend_vld_d;
         ctrl_q     <= ctrl_d;
         tgl_q      <= tgl_d;
      end
   end
   assign sda_out = 1'h0;
   assign sda_oe  = oe_q;
   // ----------------------------------------
   // Crossing of committed selection
   // ----------------------------------------
   ics_sync #(.WIDTH(1), .RESET_VALUE(1'h0)) u_tgl_sync
   (
      .clock    (clock),
      .reset    (reset),
      .async_in (tgl_q),
      .sync_out (tgl_s)
   );
   wire chan_load = tgl_s ^ tgl_prev_q;
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         tgl_prev_q <= 1'h0;
         chan_q     <= `ICS_CTRL_RESET;
      end
      else
      begin
         tgl_prev_q <= tgl_s;
         if (chan_load)
         begin
            chan_q <= ctrl_q;
         end
      end
   end
   assign channel_enable = chan_q;
endmodule

// ---- ics_target_properties.sv ----
// Concurrent checks on the channel-select target ports
`timescale 1ns/10ps

module ics_target_properties
#(
   parameter int CHAN_BITS = 3,
   parameter int ADDR_BITS = 7
)
(
   // Clocks and resets
   input wire logic                 clock,
   input wire logic                 reset,
   input wire logic                 link_clock,
   input wire logic                 reset_line_n,
   // Bus and switch
   input wire logic                 scl_in,
   input wire logic                 sda_in,
   input wire logic                 sda_out,
   input wire logic                 sda_oe,
   input wire logic [ADDR_BITS-1:0] device_address,
   input wire logic [CHAN_BITS-1:0] channel_enable
);
   // ----------------------------------------
   // Bit count since start, ages of stop and pin reset
   // ----------------------------------------
   logic       scl_q;
   logic       sda_q;
   logic       csda_q;
   logic [3:0] rise_q;
   logic [7:0] stop_age_q;
   logic [7:0] pin_age_q;

   always_ff @(posedge link_clock or posedge reset)
      if (reset)
         {scl_q, sda_q, rise_q} <= {2'b11, 4'hF};
      else
      begin
         {scl_q, sda_q} <= {scl_in, sda_in};
         if (scl_in && sda_q && !sda_in)
            rise_q <= 4'h0;
         else if (scl_in && !scl_q && rise_q != 4'hF)
            rise_q <= rise_q + 4'h1;
      end

   always_ff @(posedge clock or posedge reset)
      if (reset)
         {csda_q, stop_age_q, pin_age_q} <= {1'b1, 16'hFFFF};
      else
      begin
         csda_q     <= sda_in;
         stop_age_q <= (scl_in && sda_in && !csda_q) ? 8'h00 : stop_age_q + {7'h00, stop_age_q != 8'hFF};
         pin_age_q  <= reset_line_n ? pin_age_q + {7'h00, pin_age_q != 8'hFF} : 8'h00;
      end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_sda_out_low: assert property (@(posedge link_clock) disable iff (reset) sda_oe |-> !sda_out)
      else $error("data line driven high");
   chk_ack_ninth_bit: assert property (@(posedge link_clock) disable iff (reset)
      $rose(sda_oe) && rise_q < 4'h9 |-> rise_q == 4'h8) else $error("address ack at wrong bit");
   chk_oe_high_phase: assert property (@(posedge link_clock) disable iff (reset)
      scl_in && scl_q && reset_line_n |-> $stable(sda_oe)) else $error("data drive moved while clock high");
   chk_oe_holds_bit: assert property (@(posedge link_clock) disable iff (reset)
      $rose(sda_oe) |-> sda_oe [*6]) else $error("data drive too short");
   chk_idle_after_rst: assert property (@(posedge link_clock) disable iff (reset)
      $fell(reset) |-> !sda_oe [*8]) else $error("data driven after reset");
   chk_reset_sel_zero: assert property (@(posedge clock) disable iff (reset)
      $fell(reset) |-> (channel_enable == '0) [*8]) else $error("select not cleared by reset");
   chk_sel_at_stop: assert property (@(posedge clock) disable iff (reset)
      $changed(channel_enable) |-> stop_age_q < 8'h3C || pin_age_q < 8'h3C) else $error("select changed off stop");
   chk_pin_clears_sel: assert property (@(posedge clock) disable iff (reset)
      $fell(reset_line_n) ##1 !reset_line_n [*8] |-> ##[0:40] channel_enable == '0) else $error("pin kept select");
   cover property (@(posedge clock) disable iff (reset) $changed(channel_enable));
   cover property (@(posedge link_clock) disable iff (reset) $rose(sda_oe) && rise_q == 4'h8);
   cover property (@(posedge clock) disable iff (reset) !reset_line_n && channel_enable != '0);
endmodule

bind ics_target ics_target_properties #(.CHAN_BITS(CHAN_BITS), .ADDR_BITS(ADDR_BITS)) u_ics_target_properties
(
   .clock(clock), .reset(reset), .link_clock(link_clock), .reset_line_n(reset_line_n), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .device_address(device_address),
   .channel_enable(channel_enable)
);

// ---- ics_target_tb.sv ----
// Self-checking bench for the channel-select serial target
`timescale 1ns/10ps

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end

module ics_target_tb;
   logic        clock = 1'b0;
   logic        link_clock = 1'b0;
   logic        reset = 1'b1;
   logic        reset_line_n = 1'b1;
   logic        slow = 1'b0;
   logic [6:0]  device_address;
   logic [2:0]  channel_enable;
   logic        sda_out, sda_oe, scl, m_low, rx_stb;
   logic [7:0]  rx_data;
   wire         sda_line = !((sda_oe && !sda_out) || m_low);
   logic [31:0] seed = 32'hFAD5D3EE;
   logic [7:0]  exp_q[$];
   logic [2:0]  sel = 3'h0;
   int          error_cnt = 0;
   int          cmp_count = 0;

   always #2 clock = !clock;
   always #7.5 link_clock = !link_clock;

   ics_target u_ics_target
   (
      .clock(clock), .reset(reset), .link_clock(link_clock), .reset_line_n(reset_line_n), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .device_address(device_address),
      .channel_enable(channel_enable)
   );
   ics_master u_ics_master
   (
      .slow(slow), .scl(scl), .sda_drv(m_low), .sda(sda_line), .rx_data(rx_data), .rx_stb(rx_stb)
   );

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wait_sel();
      int k;
      repeat (60) @(negedge clock);
      for (k = 0; k < 200 && channel_enable !== sel; k++)
         @(negedge clock);
      `CHK("channel select", sel, channel_enable)
      if (k == 200)
         finish_test();
      @(posedge clock);
   endtask

   task automatic xfer(input logic rd, input int n, input logic [2:0] c);
      logic [31:0] r;
      u_ics_master.start();
      exp_q.push_back(8'h00);
      u_ics_master.wbyte({device_address, rd});
      for (int i = 0; i < n; i++)
      begin
         r = rnd();
         exp_q.push_back(rd ? {5'h00, sel} : 8'h00);
         if (rd)
            u_ics_master.rbyte(i < n - 1);
         else
            u_ics_master.wbyte({r[7:3], (i == n - 1) ? c : r[2:0]});
      end
      `CHK("select before stop", sel, channel_enable)
   endtask

   task automatic wr(input int n, input logic [2:0] c);
      xfer(1'b0, n, c);
      u_ics_master.stop();
      sel = (n > 0) ? c : sel;
      wait_sel();
   endtask

   task automatic rd(input int n);
      xfer(1'b1, n, 3'h0);
      u_ics_master.stop();
   endtask

   initial
   begin
      logic [7:0] e;
      #1;
      forever
      begin
         @(rx_stb);
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         `CHK("bus unit", e, rx_data)
      end
   end

   initial
   begin
      logic [31:0] r;
      r = rnd();
      device_address <= r[6:0];
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      repeat (10) @(posedge link_clock);
      @(negedge clock);
      `CHK("reset drive", 1'b0, sda_oe)
      @(posedge clock);
      rd(1);
      $display("test reset defaults done");
      for (int c = 0; c < 8; c++)
      begin
         wr(1, c[2:0]);
         rd(2);
      end
      wr(4, 3'h5);
      rd(5);
      $display("test codes and counts done");
      @(posedge clock);
      slow <= 1'b1;
      wr(2, 3'h6);
      rd(3);
      slow <= 1'b0;
      $display("test slow controller done");
      u_ics_master.start();
      exp_q.push_back(8'h01);
      u_ics_master.wbyte({device_address ^ 7'h01, 1'b0});
      exp_q.push_back(8'h01);
      u_ics_master.wbyte(8'h07);
      u_ics_master.stop();
      wait_sel();
      wr(0, 3'h1);
      $display("test refused and empty done");
      xfer(1'b0, 1, 3'h2);
      xfer(1'b1, 2, 3'h0);
      u_ics_master.stop();
      sel = 3'h2;
      wait_sel();
      $display("test repeated start done");
      @(posedge clock);
      reset_line_n <= 1'b0;
      repeat (40) @(posedge clock);
      reset_line_n <= 1'b1;
      sel = 3'h0;
      wait_sel();
      rd(1);
      $display("test reset pin done");
      wr(1, 3'h7);
      reset <= 1'b1;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      sel = 3'h0;
      repeat (10) @(posedge link_clock);
      @(negedge clock);
      `CHK("select after reset", 3'h0, channel_enable)
      @(posedge clock);
      rd(1);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule
